// >>> hdl/dwm_pkg.sv
// Purpose: shared constants and helpers for the data watchpoint block
// Assumes: 32-bit Avalon-MM register bus, byte addressed, one word per register
// Notes: all offsets and fields, the control and address reset values and the bus state codes live here
package dwm_pkg;

  // register byte offsets
  localparam logic [4:0] OFS_CONTROL = 5'h00;
  localparam logic [4:0] OFS_ADDRESS = 5'h04;
  localparam logic [4:0] OFS_STATUS = 5'h08;
  localparam logic [4:0] OFS_CLEAR = 5'h0C;
  localparam logic [4:0] OFS_ENABLE = 5'h10;
  localparam logic [4:0] OFS_HIT_ADDR = 5'h14;
  localparam logic [4:0] OFS_HIT_COUNT = 5'h18;

  // control register field positions
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_PRIV_LSB = 1;
  localparam int CTRL_TYPE_LSB = 3;
  localparam int CTRL_LANE_LSB = 5;
  localparam int CTRL_HYP_BIT = 13;
  localparam int CTRL_SEC_LSB = 14;
  localparam int CTRL_LBN_LSB = 16;
  localparam int CTRL_LINK_BIT = 20;
  localparam int CTRL_MASK_LSB = 24;

  // writable bits and reset values
  localparam logic [31:0] CTRL_WMASK = 32'h1F1FFFFF;
  localparam logic [31:0] ADDR_WMASK = 32'hFFFFFFFC;
  localparam logic [31:0] CTRL_RESET = 32'h00000000;
  localparam logic [31:0] ADDR_RESET = 32'h00000000;

  // access type filter codes
  localparam logic [1:0] TYPE_RSVD = 2'h0;
  localparam logic [1:0] TYPE_ALL = 2'h3;

  // range mask: smallest usable value, reserved values
  localparam logic [4:0] MASK_MIN = 5'h03;
  localparam logic [4:0] MASK_RSVD1 = 5'h01;
  localparam logic [4:0] MASK_RSVD2 = 5'h02;

  // security filter codes
  localparam logic [1:0] SEC_NONSECURE = 2'h1;
  localparam logic [1:0] SEC_SECURE = 2'h2;

  // interrupt status bit positions
  localparam int IRQ_W = 2;
  localparam int IRQ_HIT = 0;
  localparam int IRQ_CFG = 1;

  // bus handshake states, gray ordered
  typedef enum logic [1:0] {
    DWM_BUS_IDLE = 2'b00,
    DWM_BUS_ACK = 2'b01
  } dwm_bus_e;

  // byte-enable merge of a write into a register
  function automatic logic [31:0] dwm_merge(input logic [31:0] old_val,
                                            input logic [31:0] new_val,
                                            input logic [3:0] be,
                                            input logic [31:0] wmask);
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[8*i +: 8] = new_val[8*i +: 8];
      end
    end
    return res & wmask;
  endfunction

endpackage

// >>> hdl/dwm_access_if.sv
// Purpose: carries one pipeline data access to the watchpoint comparators
// Assumes: fields valid for one clock while valid is high
// Notes: top drives it, comparator modules only read it
`timescale 1ns/1ps
interface dwm_access_if;
  logic valid;
  logic [31:0] addr;
  logic [1:0] size;
  logic load;
  logic store;
  logic priv;
  logic hyp;
  logic secure;

  modport src (output valid, addr, size, load, store, priv, hyp, secure);
  modport sink (input valid, addr, size, load, store, priv, hyp, secure);
endinterface

// >>> hdl/dwm_addr_match.sv
// Purpose: byte-lane and range-mask address comparison for one access
// Assumes: access size code 0..3 means 1, 2, 4, 8 bytes from addr
// Notes: purely combinational
`timescale 1ns/1ps
module dwm_addr_match
  import dwm_pkg::*;
(
  dwm_access_if.sink acc,
  input wire logic [31:0] watch_addr,
  input wire logic [7:0] lanes,
  input wire logic [4:0] mask,
  output logic hit
);

  // one access byte against the watched bytes
  function automatic logic byte_hit(input logic [31:0] b, input logic [31:0] base,
                                    input logic [31:0] mvec, input logic [7:0] sel);
    logic [31:0] off;
    off = b - base;
    if (mvec != 32'h00000000) begin
      return ((b ^ base) & ~mvec) == 32'h00000000;
    end
    return (off < 32'h00000008) && sel[off[2:0]];
  endfunction

  // walk every byte covered; start word may differ from watch word
  always_comb begin
    logic [31:0] base;
    logic [31:0] mvec;
    logic [3:0] nbytes;
    base = {watch_addr[31:2], 2'b00};
    mvec = (mask >= MASK_MIN) ? ((32'h00000001 << mask) - 32'h00000001) : 32'h00000000;
    nbytes = 4'h1 << acc.size;
    hit = 1'b0;
    for (int j = 0; j < 8; j++) begin
      if (4'(j) < nbytes && byte_hit(acc.addr + 32'(j), base, mvec, lanes)) begin
        hit = 1'b1;
      end
    end
  end

endmodule // dwm_addr_match

// >>> hdl/dwm_type_filter.sv
// Purpose: access-type, privilege, hyp and security filters for one access
// Assumes: swap presents load and store both high
// Notes: purely combinational
`timescale 1ns/1ps
module dwm_type_filter
  import dwm_pkg::*;
(
  dwm_access_if.sink acc,
  input wire logic [1:0] access_type_select,
  input wire logic [1:0] privilege_filter,
  input wire logic hyp_mode_filter,
  input wire logic [1:0] security_filter,
  output logic pass
);

  logic type_ok;
  logic priv_ok;
  logic sec_ok;

  // load/store kind; reserved code matches nothing
  assign type_ok = (access_type_select == TYPE_ALL) ||
                   (access_type_select[0] && acc.load) ||
                   (access_type_select[1] && acc.store);

  // mode filter; hyp accesses ignore the privilege field
  assign priv_ok = acc.hyp ? hyp_mode_filter
                 : (acc.priv ? privilege_filter[0] : privilege_filter[1]);

  // security state filter
  assign sec_ok = (security_filter == SEC_NONSECURE) ? !acc.secure
                : (security_filter == SEC_SECURE) ? acc.secure : 1'b1;

  assign pass = type_ok && priv_ok && sec_ok;

endmodule // dwm_type_filter

// >>> hdl/dwm_top.sv
// Purpose: data watchpoint comparator with Avalon-MM control registers
// Assumes: pipeline access inputs are synchronous and valid for one clock
// Notes: debug event is a one-clock pulse one cycle after the access
//
// Notes on behaviour
// - control bits 12:5 select which of eight bytes are watched
// - watch address is word aligned; with no range mask (mask below 3) only selected bytes of that region match
// - any overlap with a watched byte hits, for any access width
// - unaligned access starting in another word still hits on overlap
// - access type 01 matches loads, exclusive loads and swaps
// - access type 10 matches stores, exclusive stores and swaps
// - access type 11 matches all; 00 is reserved for software
// - privilege filter bits 2:1 qualify match by processor mode
// - control bit 0 enables the watchpoint
// - disabled watchpoint never raises a debug event
// - mask bits 28:24 drop low address bits; values 1, 2 reserved
// - link bit 20 also requires the linked context match
// - security filter bits 15:14 qualify match by security state
//
// The Avalon-MM slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps
module dwm_top
  import dwm_pkg::*;
#(
  parameter int COUNT_W = 16
)
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic acc_valid,
  input wire logic [31:0] acc_addr,
  input wire logic [1:0] acc_size,
  input wire logic acc_load,
  input wire logic acc_store,
  input wire logic acc_priv,
  input wire logic acc_hyp,
  input wire logic acc_secure,
  input wire logic ctx_match,
  output logic [3:0] linked_break_index,
  output logic wp_event,
  output logic irq
);

  // package items used throughout the body
  import dwm_pkg::*;

  // register state
  logic [31:0] watch_control_reg;
  logic [31:0] watch_address_reg;
  logic [IRQ_W-1:0] irq_status_reg;
  logic [IRQ_W-1:0] irq_enable_reg;
  logic [31:0] hit_addr_reg;
  logic [COUNT_W-1:0] hit_count_reg;
  logic [31:0] readdata_reg;
  logic event_reg;
  logic cfg_bad_reg;
  dwm_bus_e bus_state_reg;
  dwm_bus_e bus_state_next;

  // control fields
  logic wp_enable;
  logic [1:0] privilege_filter;
  logic [1:0] access_type_select;
  logic [7:0] byte_lane_select;
  logic hyp_mode_filter;
  logic [1:0] security_filter;
  logic link_type;
  logic [4:0] range_mask;

  // bus decode
  logic bus_req;
  logic bus_done;
  logic wr_done;
  logic [31:0] read_mux;

  // match results
  logic addr_hit;
  logic filter_pass;
  logic link_ok;
  logic hit_now;
  logic cfg_bad;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;
  logic [IRQ_W-1:0] irq_status_next;
  logic cfg_rise;

  // per-register write strobes
  logic wr_control;
  logic wr_address;
  logic wr_enable;
  logic wr_clear;

  // programming faults
  logic type_rsvd;
  logic mask_rsvd;
  logic index_stray;

  // interface instance for the comparators
  dwm_access_if acc_bus ();

  // field extraction from the control register

  // split control register into named fields
  assign wp_enable = watch_control_reg[CTRL_EN_BIT];
  assign privilege_filter = watch_control_reg[CTRL_PRIV_LSB +: 2];
  assign access_type_select = watch_control_reg[CTRL_TYPE_LSB +: 2];
  assign byte_lane_select = watch_control_reg[CTRL_LANE_LSB +: 8];
  assign hyp_mode_filter = watch_control_reg[CTRL_HYP_BIT];
  assign security_filter = watch_control_reg[CTRL_SEC_LSB +: 2];
  assign linked_break_index = watch_control_reg[CTRL_LBN_LSB +: 4];
  assign link_type = watch_control_reg[CTRL_LINK_BIT];
  assign range_mask = watch_control_reg[CTRL_MASK_LSB +: 5];

  // access carrier towards the comparators

  // drive the access interface from the pipeline pins
  assign acc_bus.valid = acc_valid;
  assign acc_bus.addr = acc_addr;
  assign acc_bus.size = acc_size;
  assign acc_bus.load = acc_load;
  assign acc_bus.store = acc_store;
  assign acc_bus.priv = acc_priv;
  assign acc_bus.hyp = acc_hyp;
  assign acc_bus.secure = acc_secure;

  // byte lane and range comparison
  dwm_addr_match u_addr_match (
    .acc(acc_bus.sink),
    .watch_addr(watch_address_reg),
    .lanes(byte_lane_select),
    .mask(range_mask),
    .hit(addr_hit)
  );

  // access kind, mode and security filters
  dwm_type_filter u_type_filter (
    .acc(acc_bus.sink),
    .access_type_select(access_type_select),
    .privilege_filter(privilege_filter),
    .hyp_mode_filter(hyp_mode_filter),
    .security_filter(security_filter),
    .pass(filter_pass)
  );

  // hit decision

  // unlinked ignores context; linked needs the breakpoint context hit
  assign link_ok = !link_type || ctx_match;

  // every condition in one access, gated by enable
  assign hit_now = wp_enable &&
                   acc_valid &&
                   addr_hit &&
                   filter_pass &&
                   link_ok;

  // registered one-clock debug event
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      event_reg <= 1'b0;
    end else begin
      event_reg <= hit_now;
    end
  end

  // event output straight from its flop
  assign wp_event = event_reg;

  // capture address of the most recent hitting access
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      hit_addr_reg <= 32'h00000000;
    end else if (hit_now) begin
      hit_addr_reg <= acc_addr;
    end
  end

  // count hits, wrapping
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      hit_count_reg <= '0;
    end else if (hit_now) begin
      hit_count_reg <= hit_count_reg + COUNT_W'(1);
    end
  end

  // programming check: reserved codes or a stray linked index

  // reserved type, reserved mask or a stray linked index
  assign type_rsvd = (access_type_select == TYPE_RSVD);
  assign mask_rsvd = (range_mask == MASK_RSVD1) || (range_mask == MASK_RSVD2);
  assign index_stray = !link_type && (linked_break_index != 4'h0);

  // flags settings whose behaviour is unpredictable, only while enabled
  assign cfg_bad = wp_enable && (type_rsvd || mask_rsvd || index_stray);

  // remember previous level to raise the event once per entry
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cfg_bad_reg <= 1'b0;
    end else begin
      cfg_bad_reg <= cfg_bad;
    end
  end

  // Avalon-MM slave handshake: one wait cycle per request

  // any request on the register bus
  assign bus_req = avs_read || avs_write;

  // idle sees a request, ack releases it the next cycle
  always_comb begin
    bus_state_next = bus_state_reg;
    unique case (bus_state_reg)
      DWM_BUS_IDLE: begin
        if (bus_req) begin
          bus_state_next = DWM_BUS_ACK;
        end
      end
      DWM_BUS_ACK: begin
        bus_state_next = DWM_BUS_IDLE;
      end
      default: begin
        bus_state_next = DWM_BUS_IDLE;
      end
    endcase
  end

  // handshake state register
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      bus_state_reg <= DWM_BUS_IDLE;
    end else begin
      bus_state_reg <= bus_state_next;
    end
  end

  // ack cycle ends the transfer; wait only while the request is new
  assign bus_done = (bus_state_reg == DWM_BUS_ACK) && bus_req;
  assign wr_done = bus_done && avs_write;
  assign avs_waitrequest = bus_req && (bus_state_reg != DWM_BUS_ACK);

  // one strobe per writable offset, all on the ack edge
  assign wr_control = wr_done && (avs_address == OFS_CONTROL);
  assign wr_address = wr_done && (avs_address == OFS_ADDRESS);
  assign wr_enable = wr_done && (avs_address == OFS_ENABLE) && avs_byteenable[0];
  assign wr_clear = wr_done && (avs_address == OFS_CLEAR) && avs_byteenable[0];

  // read mux; unmapped offsets read zero
  always_comb begin
    read_mux = 32'h00000000;
    unique case (avs_address)
      OFS_CONTROL: read_mux = watch_control_reg;
      OFS_ADDRESS: read_mux = watch_address_reg;
      OFS_STATUS: read_mux = 32'(irq_status_reg);
      OFS_CLEAR: read_mux = 32'h00000000; // write-only
      OFS_ENABLE: read_mux = 32'(irq_enable_reg);
      OFS_HIT_ADDR: read_mux = hit_addr_reg;
      OFS_HIT_COUNT: read_mux = 32'(hit_count_reg);
      default: read_mux = 32'h00000000;
    endcase
  end

  // read data latched in the wait cycle, stands through the ack cycle
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      readdata_reg <= 32'h00000000;
    end else if (avs_read && bus_state_reg == DWM_BUS_IDLE) begin
      readdata_reg <= read_mux;
    end
  end

  // read data straight from its flop
  assign avs_readdata = readdata_reg;

  // register writes, taken at the edge that ends the ack cycle

  // watchpoint control register
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      watch_control_reg <= CTRL_RESET;
    end else if (wr_control) begin
      watch_control_reg <= dwm_merge(watch_control_reg, avs_writedata,
                                     avs_byteenable, CTRL_WMASK);
    end
  end

  // watch address register, low two bits forced to zero
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      watch_address_reg <= ADDR_RESET;
    end else if (wr_address) begin
      watch_address_reg <= dwm_merge(watch_address_reg, avs_writedata,
                                     avs_byteenable, ADDR_WMASK);
    end
  end

  // interrupt enable register
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      irq_enable_reg <= '0;
    end else if (wr_enable) begin
      irq_enable_reg <= avs_writedata[IRQ_W-1:0];
    end
  end

  // sticky interrupt status; set beats a same-cycle clear

  // configuration fault counts once on entry
  assign cfg_rise = cfg_bad && !cfg_bad_reg;

  // event sources
  assign irq_set[IRQ_HIT] = hit_now;
  assign irq_set[IRQ_CFG] = cfg_rise;

  // write-one-to-clear through the clear register
  assign irq_clr = wr_clear ? avs_writedata[IRQ_W-1:0] : '0;

  // next status: clear first, then new events on top
  assign irq_status_next = (irq_status_reg & ~irq_clr) | irq_set;

  // status bits
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      irq_status_reg <= '0;
    end else begin
      irq_status_reg <= irq_status_next;
    end
  end

  // level interrupt while any enabled status bit is set
  assign irq = |(irq_status_reg & irq_enable_reg);

endmodule // dwm_top

// >>> test/dwm_top_props.sv
// Purpose: concurrent checks on the watchpoint top ports
// Assumes: control shadow follows bus writes at the ack edge
// Notes: bound to every dwm_top instance
`timescale 1ns/1ps
module dwm_top_props
  import dwm_pkg::*;
#(
  parameter int COUNT_W = 16
)
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic acc_valid,
  input wire logic [31:0] acc_addr,
  input wire logic [1:0] acc_size,
  input wire logic acc_load,
  input wire logic acc_store,
  input wire logic acc_priv,
  input wire logic acc_hyp,
  input wire logic acc_secure,
  input wire logic ctx_match,
  input wire logic [3:0] linked_break_index,
  input wire logic wp_event,
  input wire logic irq
);
  logic [23:0] ctl_sh;
  logic req;
  // request present on the bus
  assign req = avs_read | avs_write;
  // shadow of control bytes 0..2, loaded at the write ack edge
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ctl_sh <= 24'h000000;
    end else if (avs_write && !avs_waitrequest && avs_address == OFS_CONTROL) begin
      for (int k = 0; k < 3; k++) begin
        if (avs_byteenable[k]) begin
          ctl_sh[8*k +: 8] <= avs_writedata[8*k +: 8];
        end
      end
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  chk_event_needs_en: assert property (wp_event |-> $past(acc_valid) && $past(ctl_sh[0]))
    else $error("event without an enabled access");
  chk_type_not_rsvd: assert property (wp_event |-> $past(ctl_sh[4:3]) != TYPE_RSVD)
    else $error("event with reserved access type");
  chk_type_load: assert property (wp_event && $past(ctl_sh[4:3]) == 2'h1 |-> $past(acc_load))
    else $error("load filter passed a non-load");
  chk_type_store: assert property (wp_event && $past(ctl_sh[4:3]) == 2'h2 |-> $past(acc_store))
    else $error("store filter passed a non-store");
  chk_priv_mode: assert property (wp_event && !$past(acc_hyp) |->
    ($past(acc_priv) ? $past(ctl_sh[1]) : $past(ctl_sh[2])))
    else $error("privilege filter ignored");
  chk_sec_state: assert property (wp_event |->
    !($past(ctl_sh[15:14]) == SEC_SECURE && !$past(acc_secure)) &&
    !($past(ctl_sh[15:14]) == SEC_NONSECURE && $past(acc_secure)))
    else $error("security filter ignored");
  chk_link_ctx: assert property (wp_event && $past(ctl_sh[20]) |-> $past(ctx_match))
    else $error("linked event without context match");
  chk_index_out: assert property (linked_break_index == ctl_sh[19:16])
    else $error("linked index output differs from control");
  chk_wait_one: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus wait longer than one cycle");
  chk_wait_idle: assert property (!req |-> !avs_waitrequest)
    else $error("waitrequest without a request");
  cov_event: cover property (wp_event);
  cov_irq: cover property (irq);
  cov_link: cover property (wp_event && $past(ctl_sh[20]));
endmodule // dwm_top_props

bind dwm_top dwm_top_props #(.COUNT_W(COUNT_W)) u_dwm_top_props (.clock(clock),
  .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .acc_valid(acc_valid),
  .acc_addr(acc_addr), .acc_size(acc_size), .acc_load(acc_load), .acc_store(acc_store),
  .acc_priv(acc_priv), .acc_hyp(acc_hyp), .acc_secure(acc_secure), .ctx_match(ctx_match),
  .linked_break_index(linked_break_index), .wp_event(wp_event), .irq(irq));

// >>> test/dwm_pipe_model.sv
// Purpose: load/store pipeline model presenting one access at a time
// Assumes: caller enters issue just after a rising edge or at time zero
// Notes: idle address, load and store flip so stale values are never mistaken for live ones
`timescale 1ns/1ps
module dwm_pipe_model (
  input wire logic clock,
  output logic acc_valid,
  output logic [31:0] acc_addr,
  output logic [1:0] acc_size,
  output logic acc_load,
  output logic acc_store,
  output logic acc_priv,
  output logic acc_hyp,
  output logic acc_secure
);
  // idle values at time zero
  initial begin
    acc_valid = 1'b0;
    acc_addr = 32'h00000000;
    acc_size = 2'h0;
    acc_load = 1'b0;
    acc_store = 1'b0;
    acc_priv = 1'b0;
    acc_hyp = 1'b0;
    acc_secure = 1'b0;
  end
  // one access for one clock, then the fields go stale
  task automatic issue(input logic [31:0] a, input logic [1:0] sz, input logic ld,
                       input logic st, input logic pv, input logic sc, input logic hy);
    @(posedge clock);
    acc_valid <= 1'b1;
    acc_addr <= a;
    acc_size <= sz;
    acc_load <= ld;
    acc_store <= st;
    acc_priv <= pv;
    acc_secure <= sc;
    acc_hyp <= hy;
    @(posedge clock);
    acc_valid <= 1'b0;
    acc_addr <= ~a;
    acc_load <= ~ld;
    acc_store <= ~st;
  endtask
endmodule // dwm_pipe_model

// >>> test/dwm_top_tb.sv
// Purpose: self-checking bench for the data watchpoint block
// Assumes: one wait cycle on the register bus, event one cycle after access
// Notes: expectations come from the field layout, not from the design
`timescale 1ns/1ps
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin n_errors++; \
  $display("[ERR] %0t got %h expected %h", $time, got, exp); end end
module dwm_top_tb;
  import dwm_pkg::*;
  logic clock, sys_rst, avs_read, avs_write, avs_waitrequest, ctx_match, wp_event, irq;
  logic acc_valid, acc_load, acc_store, acc_priv, acc_hyp, acc_secure, hyp_sel;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, acc_addr, rd;
  logic [3:0] avs_byteenable, linked_break_index;
  logic [1:0] acc_size;
  int n_errors, checks_done, cycles;
  dwm_top u_dwm_top (.clock(clock), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .acc_valid(acc_valid), .acc_addr(acc_addr),
    .acc_size(acc_size), .acc_load(acc_load), .acc_store(acc_store), .acc_priv(acc_priv),
    .acc_hyp(acc_hyp), .acc_secure(acc_secure), .ctx_match(ctx_match),
    .linked_break_index(linked_break_index), .wp_event(wp_event), .irq(irq));
  dwm_pipe_model u_dwm_pipe_model (.clock(clock), .acc_valid(acc_valid),
    .acc_addr(acc_addr), .acc_size(acc_size), .acc_load(acc_load), .acc_store(acc_store),
    .acc_priv(acc_priv), .acc_hyp(acc_hyp), .acc_secure(acc_secure));
  // 25 MHz clock
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // verdict and end of run
  task automatic close_out();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // hang guard
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      close_out();
    end
  end
  // control word, enable set, hyp filter and linked index clear
  function automatic logic [31:0] mk(input logic [7:0] ln, input logic [1:0] ty,
    input logic [1:0] pv, input logic [1:0] sc, input logic lk, input logic [4:0] ms);
    return {3'h0, ms, 3'h0, lk, 4'h0, sc, 1'b0, ln, ty, pv, 1'b1};
  endfunction
  // one bus cycle, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge clock);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d, rd);
  endtask
  // access through the pipeline model, event judged in the following cycle
  task automatic acc(input logic [31:0] a, input logic [1:0] sz, input logic ld,
    input logic st, input logic pv, input logic sc, input logic exp);
    u_dwm_pipe_model.issue(a, sz, ld, st, pv, sc, hyp_sel);
    #1;
    `CHK(wp_event, exp)
  endtask
  task automatic t_regs();
    bus(1'b0, OFS_CONTROL, 32'h0, rd);
    `CHK(rd, 32'h00000000)
    wr(OFS_CONTROL, 32'hFFFFFFFF);
    bus(1'b0, OFS_CONTROL, 32'h0, rd);
    `CHK(rd, CTRL_WMASK)
    `CHK(linked_break_index, 4'hF)
    wr(OFS_ADDRESS, 32'hFFFFFFFF);
    bus(1'b0, OFS_ADDRESS, 32'h0, rd);
    `CHK(rd, 32'hFFFFFFFC)
    wr(5'h1C, 32'hFFFFFFFF);
    bus(1'b0, 5'h1C, 32'h0, rd);
    `CHK(rd, 32'h00000000)
    $display("t_regs done");
  endtask
  task automatic t_lanes();
    wr(OFS_ADDRESS, 32'h00000100);
    wr(OFS_CONTROL, mk(8'h10, 2'h3, 2'h3, 2'h0, 1'b0, 5'h00));
    acc(32'h104, 2'h0, 1, 0, 1, 0, 1'b1);
    acc(32'h100, 2'h0, 1, 0, 1, 0, 1'b0);
    acc(32'h105, 2'h0, 1, 0, 1, 0, 1'b0);
    acc(32'h104, 2'h2, 1, 0, 1, 0, 1'b1);
    acc(32'h100, 2'h3, 1, 0, 1, 0, 1'b1);
    acc(32'h103, 2'h1, 1, 0, 1, 0, 1'b1);
    wr(OFS_CONTROL, mk(8'h01, 2'h3, 2'h3, 2'h0, 1'b0, 5'h00));
    acc(32'h0FE, 2'h2, 1, 0, 1, 0, 1'b1);
    acc(32'h0FE, 2'h1, 1, 0, 1, 0, 1'b0);
    wr(OFS_CONTROL, mk(8'h00, 2'h3, 2'h3, 2'h0, 1'b0, 5'h03));
    acc(32'h106, 2'h0, 1, 0, 1, 0, 1'b1);
    acc(32'h108, 2'h0, 1, 0, 1, 0, 1'b0);
    $display("t_lanes done");
  endtask
  task automatic t_types();
    logic e;
    wr(OFS_ADDRESS, 32'h00000200);
    for (int ty = 0; ty < 4; ty++) begin
      wr(OFS_CONTROL, mk(8'hFF, 2'(ty), 2'h3, 2'h0, 1'b0, 5'h00));
      for (int k = 0; k < 4; k++) begin
        e = (ty == 3) ? 1'b1 : (ty == 1) ? k[0] : (ty == 2) ? k[1] : 1'b0;
        acc(32'h200, 2'h2, k[0], k[1], 1, 0, e);
      end
    end
    $display("t_types done");
  endtask
  task automatic t_filters();
    wr(OFS_CONTROL, mk(8'hFF, 2'h3, 2'h3, 2'h0, 1'b0, 5'h00) & 32'hFFFFFFFE);
    acc(32'h200, 2'h2, 1, 0, 1, 0, 1'b0);
    wr(OFS_CONTROL, mk(8'hFF, 2'h3, 2'h1, 2'h2, 1'b0, 5'h00));
    acc(32'h200, 2'h2, 1, 0, 1, 1, 1'b1);
    acc(32'h200, 2'h2, 1, 0, 0, 1, 1'b0);
    acc(32'h200, 2'h2, 1, 0, 1, 0, 1'b0);
    wr(OFS_CONTROL, mk(8'hFF, 2'h3, 2'h2, 2'h1, 1'b0, 5'h00));
    acc(32'h200, 2'h2, 1, 0, 0, 0, 1'b1);
    acc(32'h200, 2'h2, 1, 0, 1, 0, 1'b0);
    acc(32'h200, 2'h2, 1, 0, 0, 1, 1'b0);
    wr(OFS_CONTROL, mk(8'hFF, 2'h3, 2'h3, 2'h0, 1'b1, 5'h00));
    acc(32'h200, 2'h2, 1, 0, 1, 0, 1'b0);
    @(posedge clock);
    ctx_match <= 1'b1;
    acc(32'h200, 2'h2, 1, 0, 1, 0, 1'b1);
    @(posedge clock);
    ctx_match <= 1'b0;
    wr(OFS_CONTROL, mk(8'hFF, 2'h3, 2'h0, 2'h0, 1'b0, 5'h00) | 32'h00002000);
    hyp_sel = 1'b1;
    acc(32'h200, 2'h2, 1, 0, 0, 0, 1'b1);
    wr(OFS_CONTROL, mk(8'hFF, 2'h3, 2'h3, 2'h0, 1'b0, 5'h00));
    acc(32'h200, 2'h2, 1, 0, 1, 0, 1'b0);
    hyp_sel = 1'b0;
    $display("t_filters done");
  endtask
  task automatic t_irq();
    wr(OFS_CONTROL, mk(8'hFF, 2'h3, 2'h3, 2'h0, 1'b0, 5'h00));
    wr(OFS_CLEAR, 32'h00000003);
    wr(OFS_ENABLE, 32'h00000001);
    acc(32'h203, 2'h0, 0, 1, 1, 0, 1'b1);
    `CHK(irq, 1'b1)
    bus(1'b0, OFS_HIT_ADDR, 32'h0, rd);
    `CHK(rd, 32'h00000203)
    wr(OFS_ENABLE, 32'h00000000);
    #1;
    `CHK(irq, 1'b0)
    wr(OFS_ENABLE, 32'h00000001);
    wr(OFS_CLEAR, 32'h00000001);
    #1;
    `CHK(irq, 1'b0)
    bus(1'b0, OFS_STATUS, 32'h0, rd);
    `CHK(rd, 32'h00000000)
    $display("t_irq done");
  endtask
  // reset, then every scenario in turn
  initial begin
    sys_rst = 1'b1;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h00000000;
    avs_byteenable = 4'hF;
    ctx_match = 1'b0;
    hyp_sel = 1'b0;
    n_errors = 0;
    checks_done = 0;
    cycles = 0;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    t_regs();
    t_lanes();
    t_types();
    t_filters();
    t_irq();
    close_out();
  end
endmodule // dwm_top_tb
